// [pkg/dac_ctrl_pkg.sv]
package dac_ctrl_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] PAGE_OFFSET = 8'h00;
  localparam logic [7:0] SOFT_RESET_OFFSET = 8'h01;
  localparam logic [7:0] DEVICE_MISC_OFFSET = 8'h02;
  localparam logic [7:0] SUPPLY_STATUS_OFFSET = 8'h03;
  localparam logic [7:0] GENERAL_MISC_OFFSET = 8'h04;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] SOFT_RESET_RESET = 8'h00;
  localparam logic [7:0] DEVICE_MISC_RESET = 8'h00;
  localparam logic [7:0] SUPPLY_STATUS_RESET = 8'h00;
  localparam logic [7:0] GENERAL_MISC_RESET = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SOFT_RESET_BIT = 0;
  localparam int QCHG_LSB = 4;
  localparam int QCHG_MSB = 5;
  localparam int SLEEP_EXIT_REF_BIT = 3;
  localparam int ANALOG_SELECT_BIT = 2;
  localparam int IO_SELECT_BIT = 1;
  localparam int SLEEP_CONTROL_BIT = 0;
  localparam int ANALOG_FORCED_BIT = 7;
  localparam int IO_FORCED_BIT = 6;
  localparam int BROWNOUT_FLAG_BIT = 1;
  localparam int BROWNOUT_WAKE_BIT = 0;
  localparam int CLOCK_ERR_IGNORE_BIT = 6;
  localparam int BROADCAST_BIT = 1;

  // writable masks; all other bits are reserved or read-only
  localparam logic [7:0] SOFT_RESET_WMASK = 8'h01;
  localparam logic [7:0] DEVICE_MISC_WMASK = 8'h3F;
  localparam logic [7:0] SUPPLY_STATUS_WMASK = 8'h01;
  localparam logic [7:0] GENERAL_MISC_WMASK = 8'h42;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLOCK_HZ = 10_000_000;
  localparam int QCHG_US_0 = 3500;
  localparam int QCHG_US_1 = 10000;
  localparam int QCHG_US_2 = 50000;
  localparam int QCHG_US_3 = 100000;
  localparam int QCHG_CYC_0 = QCHG_US_0 * (CLOCK_HZ / 1_000_000);
  localparam int QCHG_CYC_1 = QCHG_US_1 * (CLOCK_HZ / 1_000_000);
  localparam int QCHG_CYC_2 = QCHG_US_2 * (CLOCK_HZ / 1_000_000);
  localparam int QCHG_CYC_3 = QCHG_US_3 * (CLOCK_HZ / 1_000_000);
  localparam int QCHG_CNT_W = 20;

  // ----------------------------------------
  // bundles
  // ----------------------------------------
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

  typedef struct packed {
    logic analog_is_3v3;
    logic io_is_3v3;
    logic brownout;
  } supply_detect_t;

  typedef enum logic [1:0] {
    QCHG_3P5MS,
    QCHG_10MS,
    QCHG_50MS,
    QCHG_100MS
  } qchg_code_t;

endpackage

// [hw/quick_charge_timer.sv]
`timescale 1ns/10ps
`default_nettype none

module quick_charge_timer
  import dac_ctrl_pkg::*;
#(
  parameter int CYC_0 = QCHG_CYC_0,
  parameter int CYC_1 = QCHG_CYC_1,
  parameter int CYC_2 = QCHG_CYC_2,
  parameter int CYC_3 = QCHG_CYC_3
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire qchg_code_t code_i,
  output logic charging_o
);

  // every period must fit the down-counter and be at least one cycle
  if (CYC_0 < 1 || CYC_1 < 1 || CYC_2 < 1 || CYC_3 < 1 ||
      CYC_0 >= (1 << QCHG_CNT_W) || CYC_1 >= (1 << QCHG_CNT_W) ||
      CYC_2 >= (1 << QCHG_CNT_W) || CYC_3 >= (1 << QCHG_CNT_W)) begin : g_bad_counts
    $error("quick charge counts out of range");
  end

  logic [QCHG_CNT_W-1:0] count_reg;
  logic [QCHG_CNT_W-1:0] load_value;

  // select the charge period for the code
  assign load_value = (code_i == QCHG_3P5MS) ? QCHG_CNT_W'(CYC_0) :
                      (code_i == QCHG_10MS) ? QCHG_CNT_W'(CYC_1) :
                      (code_i == QCHG_50MS) ? QCHG_CNT_W'(CYC_2) : QCHG_CNT_W'(CYC_3);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_reg <= '0;
      charging_o <= 1'b0;
    end else if (start_i) begin
      count_reg <= load_value - QCHG_CNT_W'(1);
      charging_o <= 1'b1;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - QCHG_CNT_W'(1);
    end else begin
      charging_o <= 1'b0;
    end
  end

endmodule // quick_charge_timer

`default_nettype wire

// [hw/dac_device_control_regs.sv]
`timescale 1ns/10ps
`default_nettype none

module dac_device_control_regs
  import dac_ctrl_pkg::*;
#(
  parameter int QCHG_CYCLES_0 = QCHG_CYC_0,
  parameter int QCHG_CYCLES_1 = QCHG_CYC_1,
  parameter int QCHG_CYCLES_2 = QCHG_CYC_2,
  parameter int QCHG_CYCLES_3 = QCHG_CYC_3
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire dac_ctrl_pkg::reg_access_t access_i,
  input wire dac_ctrl_pkg::supply_detect_t detect_i,
  input wire logic clock_error_i,
  output logic [7:0] rdata_o,
  output logic sleep_o,
  output logic digital_regulator_en_o,
  output logic reference_en_o,
  output logic reference_charging_o,
  output logic analog_regulator_bypass_o,
  output logic io_supply_select_o,
  output logic clock_error_action_o,
  output logic broadcast_address_enable_o,
  output logic soft_reset_o
);
  import dac_ctrl_pkg::*;

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (QCHG_CYCLES_0 < 1 || QCHG_CYCLES_3 >= (1 << QCHG_CNT_W)) begin : g_bad_charge_counts
    $error("quick charge counts out of range");
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] soft_reset_reg;
  logic [7:0] device_misc_reg;
  logic [7:0] supply_status_reg;
  logic [7:0] general_misc_reg;
  logic [7:0] page_reg;
  logic brownout_seen_reg;
  logic awake_reg;
  logic charging;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wdata, input logic [7:0] wmask);
    merge = (old & ~wmask) | (wdata & wmask);
  endfunction

  wire page0 = (page_reg == 8'h00);
  wire wr_page = access_i.write && access_i.addr == PAGE_OFFSET;
  wire wr_soft = access_i.write && page0 && access_i.addr == SOFT_RESET_OFFSET;
  wire wr_dev = access_i.write && page0 && access_i.addr == DEVICE_MISC_OFFSET;
  wire wr_sts = access_i.write && page0 && access_i.addr == SUPPLY_STATUS_OFFSET;
  wire wr_gen = access_i.write && page0 && access_i.addr == GENERAL_MISC_OFFSET;
  wire soft_reset_fire = soft_reset_reg[SOFT_RESET_BIT];
  wire clear_all = reset_i || soft_reset_fire;

  // reserved bits held by masks; status bits never written
  wire [7:0] dev_next_raw = merge(device_misc_reg, access_i.wdata, DEVICE_MISC_WMASK);
  wire [7:0] sts_next = merge(supply_status_reg, access_i.wdata, SUPPLY_STATUS_WMASK);
  wire [7:0] gen_next = merge(general_misc_reg, access_i.wdata, GENERAL_MISC_WMASK);

  // forced select bits under 3.3V supplies
  wire analog_sel_eff = device_misc_reg[ANALOG_SELECT_BIT] & ~detect_i.analog_is_3v3;
  wire io_sel_eff = device_misc_reg[IO_SELECT_BIT] & ~detect_i.io_is_3v3;

  wire [7:0] status_view = {detect_i.analog_is_3v3, detect_i.io_is_3v3, 4'h0,
                            brownout_seen_reg, supply_status_reg[BROWNOUT_WAKE_BIT]};
  wire [7:0] device_view = {device_misc_reg[7:3], analog_sel_eff, io_sel_eff, device_misc_reg[0]};

  wire [7:0] rdata_next = !page0 && access_i.addr != PAGE_OFFSET ? 8'h00 :
                          access_i.addr == PAGE_OFFSET ? page_reg :
                          access_i.addr == SOFT_RESET_OFFSET ? soft_reset_reg :
                          access_i.addr == DEVICE_MISC_OFFSET ? device_view :
                          access_i.addr == SUPPLY_STATUS_OFFSET ? status_view :
                          access_i.addr == GENERAL_MISC_OFFSET ? general_misc_reg : 8'h00;

  // sleep control: host bit, or brownout policy
  wire sleep_ctrl = device_misc_reg[SLEEP_CONTROL_BIT];
  wire brownout_wake = supply_status_reg[BROWNOUT_WAKE_BIT];
  wire awake_next = detect_i.brownout ? brownout_wake :
                    (sleep_ctrl && !awake_reg) ? 1'b1 :
                    !sleep_ctrl ? 1'b0 : awake_reg;
  wire wake_edge = awake_next && !awake_reg;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  wire [7:0] soft_next = merge(soft_reset_reg, access_i.wdata, SOFT_RESET_WMASK);
  wire brownout_sleep_clear = detect_i.brownout && !brownout_wake;

  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      soft_reset_reg <= SOFT_RESET_RESET;
    end else if (wr_soft) begin
      soft_reset_reg <= soft_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      device_misc_reg <= DEVICE_MISC_RESET;
    end else if (wr_dev) begin
      device_misc_reg <= dev_next_raw;
    end else if (brownout_sleep_clear) begin
      device_misc_reg[SLEEP_CONTROL_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      supply_status_reg <= SUPPLY_STATUS_RESET;
    end else if (wr_sts) begin
      supply_status_reg <= sts_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      general_misc_reg <= GENERAL_MISC_RESET;
    end else if (wr_gen) begin
      general_misc_reg <= gen_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      page_reg <= 8'h00;
    end else if (wr_page) begin
      page_reg <= access_i.wdata;
    end
  end

  // brownout flag and sleep state
  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      brownout_seen_reg <= 1'b0;
    end else begin
      brownout_seen_reg <= brownout_seen_reg | detect_i.brownout;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clear_all) begin
      awake_reg <= 1'b0;
    end else begin
      awake_reg <= awake_next;
    end
  end

  // ----------------------------------------
  // quick charge of the reference
  // ----------------------------------------
  // charge stops as soon as the device heads back to sleep
  wire charge_reset = clear_all || !awake_next;
  wire charge_start = wake_edge && device_misc_reg[SLEEP_EXIT_REF_BIT];

  quick_charge_timer #(
    .CYC_0(QCHG_CYCLES_0),
    .CYC_1(QCHG_CYCLES_1),
    .CYC_2(QCHG_CYCLES_2),
    .CYC_3(QCHG_CYCLES_3)
  ) u_qchg (
    .clk_i(clk_i),
    .reset_i(charge_reset),
    .start_i(charge_start),
    .code_i(qchg_code_t'(device_misc_reg[QCHG_MSB:QCHG_LSB])),
    .charging_o(charging)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (access_i.read) begin
      rdata_o <= rdata_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sleep_o <= 1'b1;
      digital_regulator_en_o <= 1'b0;
      reference_en_o <= 1'b0;
      reference_charging_o <= 1'b0;
      analog_regulator_bypass_o <= 1'b0;
      io_supply_select_o <= 1'b0;
      clock_error_action_o <= 1'b1;
      broadcast_address_enable_o <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      sleep_o <= !awake_reg;
      digital_regulator_en_o <= awake_reg;
      reference_en_o <= awake_reg && device_misc_reg[SLEEP_EXIT_REF_BIT];
      reference_charging_o <= charging;
      analog_regulator_bypass_o <= analog_sel_eff;
      io_supply_select_o <= io_sel_eff;
      clock_error_action_o <= !general_misc_reg[CLOCK_ERR_IGNORE_BIT] && clock_error_i;
      broadcast_address_enable_o <= general_misc_reg[BROADCAST_BIT];
      soft_reset_o <= soft_reset_fire;
    end
  end

endmodule // dac_device_control_regs

`default_nettype wire

// [sim/dac_ctrl_props.sv]
`timescale 1ns/10ps
`default_nettype none

module dac_ctrl_checker
  import dac_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire dac_ctrl_pkg::reg_access_t access_i,
  input wire dac_ctrl_pkg::supply_detect_t detect_i,
  input wire logic clock_error_i,
  input wire logic [7:0] rdata_o,
  input wire logic sleep_o,
  input wire logic digital_regulator_en_o,
  input wire logic reference_en_o,
  input wire logic reference_charging_o,
  input wire logic analog_regulator_bypass_o,
  input wire logic io_supply_select_o,
  input wire logic clock_error_action_o,
  input wire logic broadcast_address_enable_o,
  input wire logic soft_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // bits that must read zero at each offset
  logic [7:0] resv;
  assign resv = (access_i.addr == 8'h00) ? 8'h00 : (access_i.addr == 8'h01) ? 8'hFE :
                (access_i.addr == 8'h02) ? 8'hC0 : (access_i.addr == 8'h03) ? 8'h3C :
                (access_i.addr == 8'h04) ? 8'hBD : 8'hFF;

  a_awake_regulator: assert property (digital_regulator_en_o == !sleep_o)
    else $error("regulator enable disagrees with sleep state");
  a_sleep_no_ref: assert property (sleep_o |-> !reference_en_o && !reference_charging_o)
    else $error("reference active while asleep");
  a_charge_on_wake: assert property ($fell(sleep_o) && reference_en_o |-> ##[0:2] reference_charging_o)
    else $error("no quick charge after wake with reference");
  a_clock_error_gate: assert property (clock_error_action_o && !$past(reset_i) |-> $past(clock_error_i))
    else $error("clock error action without clock error");
  a_soft_pulse: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset pulse longer than one cycle");
  a_soft_clears: assert property (soft_reset_o |-> ##[0:3] sleep_o && !broadcast_address_enable_o)
    else $error("soft reset left configuration set");
  a_reserved_zero: assert property (access_i.read |=> (rdata_o & $past(resv)) == 8'h00)
    else $error("reserved or unmapped bits read nonzero");
  a_io_forced: assert property (detect_i.io_is_3v3 [*3] |-> !io_supply_select_o)
    else $error("io select not forced low");
  a_analog_forced: assert property (detect_i.analog_is_3v3 [*3] |-> !analog_regulator_bypass_o)
    else $error("analog select not forced low");
endmodule // dac_ctrl_checker

bind dac_device_control_regs dac_ctrl_checker chk (.clk_i(clk_i), .reset_i(reset_i), .access_i(access_i),
  .detect_i(detect_i), .clock_error_i(clock_error_i), .rdata_o(rdata_o), .sleep_o(sleep_o),
  .digital_regulator_en_o(digital_regulator_en_o), .reference_en_o(reference_en_o),
  .reference_charging_o(reference_charging_o), .analog_regulator_bypass_o(analog_regulator_bypass_o),
  .io_supply_select_o(io_supply_select_o), .clock_error_action_o(clock_error_action_o),
  .broadcast_address_enable_o(broadcast_address_enable_o), .soft_reset_o(soft_reset_o));

`default_nettype wire

// [sim/host_model.sv]
`timescale 1ns/10ps
`default_nettype none

module host_model
  import dac_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output dac_ctrl_pkg::reg_access_t access_o
);
  initial access_o = '0;
  // one-cycle strobe; released bus shows inverted address and data
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_i);
    access_o = '{wr, !wr, a, d};
    @(negedge clk_i);
    access_o = '{1'b0, 1'b0, ~a, ~d};
    q = rdata_i;
  endtask
endmodule // host_model

`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import dac_ctrl_pkg::*;
  localparam int PC[4] = '{4, 8, 12, 16};
  logic clk_i, reset_i, clock_error_i, sleep_o, digital_regulator_en_o, reference_en_o, reference_charging_o;
  logic analog_regulator_bypass_o, io_supply_select_o, clock_error_action_o, broadcast_address_enable_o;
  logic soft_reset_o;
  logic [7:0] rdata_o, q, n;
  reg_access_t access_i;
  supply_detect_t detect_i;
  int miscompares = 0;
  int cmp_count = 0;
  // offset, written value, expected readback
  logic [23:0] rows[6] = '{24'h02FF3F, 24'h03FE00, 24'h04FF42, 24'h023030, 24'h040000, 24'h10FF00};
  wire logic [7:0] outs = {1'b0, sleep_o, digital_regulator_en_o, reference_en_o, analog_regulator_bypass_o,
                           io_supply_select_o, clock_error_action_o, broadcast_address_enable_o};

  dac_device_control_regs #(.QCHG_CYCLES_0(PC[0]), .QCHG_CYCLES_1(PC[1]), .QCHG_CYCLES_2(PC[2]),
    .QCHG_CYCLES_3(PC[3])) DUT (.clk_i(clk_i), .reset_i(reset_i), .access_i(access_i), .detect_i(detect_i),
    .clock_error_i(clock_error_i), .rdata_o(rdata_o), .sleep_o(sleep_o),
    .digital_regulator_en_o(digital_regulator_en_o), .reference_en_o(reference_en_o),
    .reference_charging_o(reference_charging_o), .analog_regulator_bypass_o(analog_regulator_bypass_o),
    .io_supply_select_o(io_supply_select_o), .clock_error_action_o(clock_error_action_o),
    .broadcast_address_enable_o(broadcast_address_enable_o), .soft_reset_o(soft_reset_o));
  host_model host (.clk_i(clk_i), .rdata_i(rdata_o), .access_o(access_i));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic settle;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic pulse_brownout;
    detect_i = 3'b001;
    @(negedge clk_i);
    detect_i = 3'b000;
    settle();
  endtask
  task automatic wrap_up;
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    reset_i = 1'b1;
    clock_error_i = 1'b0;
    detect_i = 3'b000;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    settle();
    chk(outs, 8'h40);
    for (int a = 1; a < 5; a++) rd(a[7:0], 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    // ----------------------------------------
    // quick charge per code
    // ----------------------------------------
    for (int c = 0; c < 4; c++) begin
      wr(8'h02, {2'b00, c[1:0], 4'h8});
      settle();
      wr(8'h02, {2'b00, c[1:0], 4'h9});
      n = 8'h00;
      repeat (40) begin
        @(negedge clk_i);
        n = n + reference_charging_o;
      end
      chk(n, 8'(PC[c]));
      chk(outs, 8'h30);
    end
    // ----------------------------------------
    // supplies, clock error, brownout, page, soft reset
    // ----------------------------------------
    wr(8'h02, 8'h07);
    settle();
    chk(outs, 8'h2C);
    detect_i = 3'b110;
    settle();
    chk(outs, 8'h20);
    rd(8'h03, 8'hC0);
    rd(8'h02, 8'h01);
    detect_i = 3'b000;
    clock_error_i = 1'b1;
    settle();
    chk(outs, 8'h2E);
    wr(8'h04, 8'h42);
    settle();
    chk(outs, 8'h2D);
    clock_error_i = 1'b0;
    pulse_brownout();
    rd(8'h03, 8'h02);
    chk(outs, 8'h4D);
    wr(8'h03, 8'h01);
    wr(8'h02, 8'h01);
    pulse_brownout();
    rd(8'h03, 8'h03);
    chk(outs, 8'h21);
    wr(8'h00, 8'h01);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h00);
    wr(8'h00, 8'h00);
    rd(8'h04, 8'h42);
    wr(8'h01, 8'h01);
    n = 8'h00;
    repeat (10) begin
      @(negedge clk_i);
      n = n + soft_reset_o;
    end
    chk(n, 8'h01);
    settle();
    chk(outs, 8'h40);
    rd(8'h01, 8'h00);
    rd(8'h03, 8'h00);
    wrap_up();
  end
endmodule // testbench

`default_nettype wire
